// file: include/psw_pkg.sv
package psw_pkg;

  // ****************************************************************
  // Register map of the control bus
  // ****************************************************************
  localparam logic [7:0] MODE_ADDR = 8'h00;
  localparam logic [7:0] CFG_ADDR = 8'h01;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // Operating mode field positions
  localparam int MODE_QUIET_BIT = 4;
  localparam int MODE_ALLOW_BIT = 5;
  localparam int MODE_TX_NRZ_BIT = 6;
  localparam int MODE_RX_NRZ_BIT = 7;

  // Switch route field positions
  localparam int CFG_FIRST_SEL_LSB = 0;
  localparam int CFG_SECOND_SEL_LSB = 2;
  localparam int CFG_TX_SEL_LSB = 4;
  localparam int CFG_FIRST_ON_BIT = 6;
  localparam int CFG_SECOND_ON_BIT = 7;

  // ****************************************************************
  // Switch bus codes and transmit states
  // ****************************************************************
  localparam logic [1:0] SEL_INVALID = 2'h0;
  localparam logic [1:0] SEL_RECEIVER = 2'h1;
  localparam logic [1:0] SEL_FIRST_REQ = 2'h2;
  localparam logic [1:0] SEL_SECOND_REQ = 2'h3;

  localparam logic [2:0] TM_ACTIVE = 3'h0;
  localparam logic [2:0] TM_OFF = 3'h1;

  // Symbol pair bytes placed on the internal buses
  localparam logic [7:0] HALT_PAIR = 8'h11;
  localparam logic [7:0] IDLE_PAIR = 8'h77;
  localparam logic [2:0] MAX_HALT_PAIRS = 3'h4;

  localparam int SYM_W = 10;
  localparam int FIFO_DEPTH = 8;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic parity;
    logic control;
    logic [7:0] data;
  } psw_sym_type;

  typedef struct packed {
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } psw_cb_req_type;

  function automatic logic psw_odd_parity(input logic control, input logic [7:0] data);
    psw_odd_parity = ~(^{control, data});
  endfunction

endpackage

// file: rtl/psw_sync.sv
`timescale 1ns/1ps
module psw_sync import psw_pkg::*; #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  if (WIDTH < 1) $error("psw_sync: WIDTH must be at least 1");

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_sync_out;

  // A bit moves only once the last two stages agree, filtering one-cycle glitches
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_sync_out[i] = (stage2[i] == stage3[i]) ? stage3[i] : sync_out[i];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      sync_out <= next_sync_out;
    end
  end

endmodule

// file: rtl/psw_fifo.sv
`timescale 1ns/1ps
module psw_fifo import psw_pkg::*; #(
  parameter int WIDTH = SYM_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("psw_fifo: DEPTH must be a power of two");
  if (WIDTH < 1) $error("psw_fifo: WIDTH must be at least 1");

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Storage has no reset; emptiness is carried by count alone
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule

// file: rtl/psw_top.sv
`timescale 1ns/1ps
//
// Contract
// - Quiet level one: off-transmit quiet drives positive request high, negative low.
// - Quiet level zero: off-transmit quiet drives positive request low, negative high.
// - Drive-allow zero keeps the enable pin off, but it sits high (on at level one) from reset until the synchroniser passes the level.
// - Drive-allow one in off-transmit mode keeps the enable pin off.
// - Drive-allow one in any other mode turns the enable pin on.
// - The enable-level pin picks the electrical polarity of on and off.
// - Outgoing code bit: zero sends NRZI, one sends plain NRZ.
// - Incoming code bit: zero decodes NRZI, one takes plain NRZ.
// - Bits 1:0 route invalid, receiver, first or second request to first indicate.
// - Bits 3:2 route a bus to second indicate with the same encoding.
// - Bits 5:4 choose the bus feeding the transmitter, same encoding.
// - Active transmit with invalid source: at most four halt pairs, then idles.
// - Bit 6 enables first indicate; cleared, its pins float.
// - Bit 7 enables second indicate; cleared, its pins float.
// - Route register always readable; writes are conditional, timer loads may overwrite.
// - Without second indicate port its bits still store but drive no pins.
// - Route register writes are refused while scrubbing runs.
module psw_top import psw_pkg::*; #(
  parameter bit HAS_SECOND_IND = 1'b1,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic srst,
  // Control bus
  input wire logic cb_req,
  input wire psw_cb_req_type cb_cmd,
  output logic cb_ack,
  output logic cb_refused,
  output logic [7:0] cb_rdata,
  // Timer-driven route loads and scrub state
  input wire logic scrub_timer_loader,
  input wire logic [7:0] scrub_route_value,
  input wire logic scrub_active,
  // Transmit state
  input wire logic [2:0] transmit_state_field,
  // Switch buses
  input wire psw_sym_type rx_bus,
  input wire psw_sym_type first_req_bus,
  input wire psw_sym_type second_req_bus,
  input wire logic [3:0] src_valid,
  output logic src_ready,
  // Transmitter feed
  output psw_sym_type tx_feed,
  output logic tx_feed_valid,
  input wire logic tx_feed_ready,
  // Indicate ports
  output psw_sym_type first_ind,
  output logic first_ind_oe_n,
  output psw_sym_type second_ind,
  output logic second_ind_oe_n,
  // Serial line
  input wire logic tx_line_bit,
  output logic [1:0] pmd_data_request_pair,
  input wire logic rx_line_pin,
  output logic rx_line_bit,
  // PMD transmitter enable
  input wire logic enable_polarity_pin,
  output logic pmd_transmitter_on_pin
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] operating_mode_control;
  logic [7:0] switch_route_config;
  logic [7:0] next_mode;
  logic [7:0] next_cfg;
  logic next_ack;
  logic next_refused;
  logic [7:0] next_rdata;
  logic cfg_write;
  logic mode_write;

  always_comb begin
    mode_write = cb_req && cb_cmd.write && cb_cmd.addr == MODE_ADDR;
    cfg_write = cb_req && cb_cmd.write && cb_cmd.addr == CFG_ADDR;
    next_mode = mode_write ? cb_cmd.wdata : operating_mode_control;
    next_cfg = switch_route_config;
    next_refused = 1'b0;
    // Timer load takes precedence over a bus write in the same cycle
    if (scrub_timer_loader) begin
      next_cfg = scrub_route_value;
      next_refused = cfg_write;
    end else if (cfg_write && scrub_active) begin
      next_refused = 1'b1;
    end else if (cfg_write) begin
      next_cfg = cb_cmd.wdata;
    end
    next_ack = cb_req;
    next_rdata = 8'h00;
    if (cb_req && !cb_cmd.write) begin
      case (cb_cmd.addr)
        MODE_ADDR: next_rdata = operating_mode_control;
        CFG_ADDR: next_rdata = switch_route_config;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      operating_mode_control <= MODE_RESET;
      switch_route_config <= CFG_RESET;
      cb_ack <= 1'b0;
      cb_refused <= 1'b0;
      cb_rdata <= 8'h00;
    end else begin
      operating_mode_control <= next_mode;
      switch_route_config <= next_cfg;
      cb_ack <= next_ack;
      cb_refused <= next_refused;
      cb_rdata <= next_rdata;
    end
  end

  logic quiet_level_select;
  logic pmd_drive_allow;
  logic outgoing_line_code_sel;
  logic incoming_line_code_sel;
  logic [1:0] first_sel;
  logic [1:0] second_sel;
  logic [1:0] tx_sel;
  logic first_ind_port_on;
  logic second_ind_port_on;
  logic off_transmit_mode;
  logic active_mode;

  assign quiet_level_select = operating_mode_control[MODE_QUIET_BIT];
  assign pmd_drive_allow = operating_mode_control[MODE_ALLOW_BIT];
  assign outgoing_line_code_sel = operating_mode_control[MODE_TX_NRZ_BIT];
  assign incoming_line_code_sel = operating_mode_control[MODE_RX_NRZ_BIT];
  assign first_sel = switch_route_config[CFG_FIRST_SEL_LSB +: 2];
  assign second_sel = switch_route_config[CFG_SECOND_SEL_LSB +: 2];
  assign tx_sel = switch_route_config[CFG_TX_SEL_LSB +: 2];
  assign first_ind_port_on = switch_route_config[CFG_FIRST_ON_BIT];
  assign second_ind_port_on = switch_route_config[CFG_SECOND_ON_BIT];
  assign off_transmit_mode = (transmit_state_field == TM_OFF);
  assign active_mode = (transmit_state_field == TM_ACTIVE);

  // ****************************************************************
  // Configuration switch
  // ****************************************************************
  function automatic psw_sym_type pick_bus(input logic [1:0] sel, input psw_sym_type inv,
                                           input psw_sym_type rx, input psw_sym_type fa,
                                           input psw_sym_type fb);
    case (sel)
      SEL_INVALID: pick_bus = inv;
      SEL_RECEIVER: pick_bus = rx;
      SEL_FIRST_REQ: pick_bus = fa;
      default: pick_bus = fb;
    endcase
  endfunction

  psw_sym_type halt_sym;
  psw_sym_type invalid_sym;
  logic [2:0] halt_count;
  logic [2:0] next_halt_count;
  logic [1:0] tx_sel_seen;
  psw_sym_type fifo_in;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic invalid_feed;

  always_comb begin
    halt_sym.control = 1'b1;
    halt_sym.data = HALT_PAIR;
    halt_sym.parity = psw_odd_parity(1'b1, HALT_PAIR);
    invalid_feed = active_mode && tx_sel == SEL_INVALID;
    invalid_sym.control = 1'b1;
    invalid_sym.data = (invalid_feed && halt_count >= MAX_HALT_PAIRS) ? IDLE_PAIR : HALT_PAIR;
    invalid_sym.parity = psw_odd_parity(1'b1, invalid_sym.data);
    fifo_in = pick_bus(tx_sel, invalid_sym, rx_bus, first_req_bus, second_req_bus);
    fifo_in_valid = (tx_sel == SEL_INVALID) ? 1'b1 : src_valid[tx_sel];
    src_ready = fifo_in_ready && tx_sel != SEL_INVALID;
    next_halt_count = halt_count;
    // Leaving the invalid path clears the count, so the first push after re-entry counts too
    if (!invalid_feed) begin
      next_halt_count = 3'h0;
    end else if (fifo_in_ready && halt_count < MAX_HALT_PAIRS) begin
      next_halt_count = halt_count + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      halt_count <= 3'h0;
      tx_sel_seen <= SEL_INVALID;
    end else begin
      halt_count <= next_halt_count;
      tx_sel_seen <= tx_sel;
    end
  end

  psw_fifo #(
    .WIDTH(SYM_W),
    .DEPTH(DEPTH)
  ) u_tx_fifo (
    .clk(clk),
    .srst(srst),
    .in_data(fifo_in),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .out_data(tx_feed),
    .out_valid(tx_feed_valid),
    .out_ready(tx_feed_ready)
  );

  // Whole bytes move per cycle, so a route change cannot split one
  psw_sym_type next_first_ind;
  psw_sym_type next_second_ind;
  logic next_first_oe_n;
  logic next_second_oe_n;

  always_comb begin
    next_first_ind = pick_bus(first_sel, halt_sym, rx_bus, first_req_bus, second_req_bus);
    next_first_oe_n = !first_ind_port_on;
    next_second_ind = pick_bus(second_sel, halt_sym, rx_bus, first_req_bus, second_req_bus);
    next_second_oe_n = !second_ind_port_on;
    if (!HAS_SECOND_IND) begin
      next_second_ind = '0;
      next_second_oe_n = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      first_ind <= '0;
      second_ind <= '0;
      first_ind_oe_n <= 1'b1;
      second_ind_oe_n <= 1'b1;
    end else begin
      first_ind <= next_first_ind;
      second_ind <= next_second_ind;
      first_ind_oe_n <= next_first_oe_n;
      second_ind_oe_n <= next_second_oe_n;
    end
  end

  // ****************************************************************
  // Serial line coding and transmitter enable
  // ****************************************************************
  logic [1:0] pin_sync;
  logic polarity_level;
  logic rx_line_sync;
  logic tx_nrzi_state;
  logic rx_prev;
  logic next_tx_nrzi_state;
  logic [1:0] next_pair;
  logic next_rx_bit;
  logic next_on_pin;
  logic drive_on;

  psw_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .clk(clk),
    .srst(srst),
    .async_in({enable_polarity_pin, rx_line_pin}),
    .sync_out(pin_sync)
  );

  assign polarity_level = pin_sync[1];
  assign rx_line_sync = pin_sync[0];

  always_comb begin
    next_tx_nrzi_state = tx_nrzi_state ^ tx_line_bit;
    if (off_transmit_mode) begin
      next_pair = quiet_level_select ? 2'h2 : 2'h1;
      next_tx_nrzi_state = tx_nrzi_state;
    end else if (outgoing_line_code_sel) begin
      next_pair = {tx_line_bit, !tx_line_bit};
    end else begin
      next_pair = {next_tx_nrzi_state, !next_tx_nrzi_state};
    end
    next_rx_bit = incoming_line_code_sel ? rx_line_sync : (rx_line_sync ^ rx_prev);
    drive_on = pmd_drive_allow && !off_transmit_mode;
    next_on_pin = polarity_level ? drive_on : !drive_on;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_nrzi_state <= 1'b0;
      rx_prev <= 1'b0;
      pmd_data_request_pair <= 2'h1;
      rx_line_bit <= 1'b0;
      pmd_transmitter_on_pin <= 1'b1;
    end else begin
      tx_nrzi_state <= next_tx_nrzi_state;
      rx_prev <= rx_line_sync;
      pmd_data_request_pair <= next_pair;
      rx_line_bit <= next_rx_bit;
      pmd_transmitter_on_pin <= next_on_pin;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb_chk @(posedge clk); endclocking
  default disable iff (srst);

  property p_quiet_high;
    off_transmit_mode && quiet_level_select |=> pmd_data_request_pair == 2'h2;
  endproperty
  a_quiet_high: assert property (p_quiet_high) else $error("quiet high level wrong");

  property p_quiet_low;
    off_transmit_mode && !quiet_level_select |=> pmd_data_request_pair == 2'h1;
  endproperty
  a_quiet_low: assert property (p_quiet_low) else $error("quiet low level wrong");

  property p_allow_off;
    !pmd_drive_allow |=> pmd_transmitter_on_pin == !$past(polarity_level);
  endproperty
  a_allow_off: assert property (p_allow_off) else $error("enable pin not off");

  property p_otm_off;
    pmd_drive_allow && off_transmit_mode |=> pmd_transmitter_on_pin == !$past(polarity_level);
  endproperty
  a_otm_off: assert property (p_otm_off) else $error("enable pin on in off mode");

  property p_on;
    pmd_drive_allow && !off_transmit_mode |=> pmd_transmitter_on_pin == $past(polarity_level);
  endproperty
  a_on: assert property (p_on) else $error("enable pin not on");

  property p_nrz_out;
    !off_transmit_mode && outgoing_line_code_sel |=> pmd_data_request_pair[1] == $past(tx_line_bit);
  endproperty
  a_nrz_out: assert property (p_nrz_out) else $error("NRZ output wrong");

  property p_first_route;
    first_sel == SEL_RECEIVER |=> first_ind == $past(rx_bus);
  endproperty
  a_first_route: assert property (p_first_route) else $error("first indicate route wrong");

  property p_first_float;
    !first_ind_port_on |=> first_ind_oe_n;
  endproperty
  a_first_float: assert property (p_first_float) else $error("first port driven");

  sequence s_scrub_write;
    cfg_write && scrub_active && !scrub_timer_loader;
  endsequence

  property p_scrub_refuse;
    s_scrub_write |=> $stable(switch_route_config) && cb_refused;
  endproperty
  a_scrub_refuse: assert property (p_scrub_refuse) else $error("write taken in scrub");

  property p_timer_load;
    scrub_timer_loader |=> switch_route_config == $past(scrub_route_value);
  endproperty
  a_timer_load: assert property (p_timer_load) else $error("timer load lost");

  sequence s_halt_burst;
    invalid_feed && tx_sel_seen == tx_sel && halt_count == MAX_HALT_PAIRS;
  endsequence

  property p_halt_limit;
    s_halt_burst |-> fifo_in.data == IDLE_PAIR;
  endproperty
  a_halt_limit: assert property (p_halt_limit) else $error("halt burst too long");

endmodule

// file: sim/psw_mac_model.sv
`timescale 1ns/1ps
module psw_mac_model import psw_pkg::*; (
  input wire logic clk,
  input wire logic send,
  input wire logic [1:0] ready_mode,
  input wire logic [1:0] tx_sel,
  input wire logic src_ready,
  output psw_sym_type rx_bus,
  output psw_sym_type first_req_bus,
  output psw_sym_type second_req_bus,
  output logic [3:0] src_valid,
  output logic tx_feed_ready
);
  psw_sym_type bus [4];
  logic [3:0] hold;
  logic [8:0] r;

  assign rx_bus = bus[1];
  assign first_req_bus = bus[2];
  assign second_req_bus = bus[3];

  // ****************************************************************
  // Request buses and transmit feed
  // ****************************************************************
  initial begin
    foreach (bus[i]) bus[i] = '0;
    hold = 4'h0;
    src_valid = 4'h0;
    tx_feed_ready = 1'b0;
    forever begin
      @(posedge clk);
      // Only the bus feeding the transmitter is flow controlled; the others move every cycle
      for (int i = 0; i < 4; i++) hold[i] = src_valid[i] && !src_ready && tx_sel == 2'(i);
      #1;
      for (int i = 1; i < 4; i++) begin
        if (!hold[i]) begin
          r = 9'($urandom);
          bus[i] = '{~^r, r[8], r[7:0]};
          src_valid[i] = send && 1'($urandom);
        end
      end
      tx_feed_ready = ready_mode[1] ? 1'($urandom) : ready_mode[0];
    end
  end
endmodule

// file: sim/psw_top_tb.sv
`timescale 1ns/1ps
module psw_top_tb import psw_pkg::*; ;
  localparam psw_sym_type HALTW = '{~^{1'b1, HALT_PAIR}, 1'b1, HALT_PAIR};
  localparam psw_sym_type IDLEW = '{~^{1'b1, IDLE_PAIR}, 1'b1, IDLE_PAIR};
  logic clk, srst, cb_req, cb_ack, cb_refused, scrub_timer_loader, scrub_active;
  psw_cb_req_type cb_cmd;
  logic [7:0] cb_rdata, scrub_route_value, mode_sh, cfg_sh;
  logic [2:0] tx_state;
  psw_sym_type rx_bus, first_req_bus, second_req_bus, tx_feed, first_ind, second_ind;
  psw_sym_type e_first, e_second;
  logic [3:0] src_valid;
  logic src_ready, tx_feed_valid, tx_feed_ready, first_ind_oe_n, second_ind_oe_n;
  logic tx_line_bit, rx_line_pin, rx_line_bit, enable_polarity_pin, pmd_transmitter_on_pin;
  logic [1:0] pmd_data_request_pair, ready_mode, e_pair, e_oe_n;
  logic send, rand_state, halt_mode, armed, req_d, prev_nrzi, pair_ok, e_on, pol_last;
  logic [8:0] ackq[$];
  psw_sym_type txq[$];
  int error_cnt, num_checks, pol_age, halt_cnt, n, ones;

  psw_top uut (.clk(clk), .srst(srst), .cb_req(cb_req), .cb_cmd(cb_cmd), .cb_ack(cb_ack),
    .cb_refused(cb_refused), .cb_rdata(cb_rdata), .scrub_timer_loader(scrub_timer_loader),
    .scrub_route_value(scrub_route_value), .scrub_active(scrub_active),
    .transmit_state_field(tx_state), .rx_bus(rx_bus), .first_req_bus(first_req_bus),
    .second_req_bus(second_req_bus), .src_valid(src_valid), .src_ready(src_ready),
    .tx_feed(tx_feed), .tx_feed_valid(tx_feed_valid), .tx_feed_ready(tx_feed_ready),
    .first_ind(first_ind), .first_ind_oe_n(first_ind_oe_n), .second_ind(second_ind),
    .second_ind_oe_n(second_ind_oe_n), .tx_line_bit(tx_line_bit),
    .pmd_data_request_pair(pmd_data_request_pair), .rx_line_pin(rx_line_pin),
    .rx_line_bit(rx_line_bit), .enable_polarity_pin(enable_polarity_pin),
    .pmd_transmitter_on_pin(pmd_transmitter_on_pin));

  psw_mac_model mac (.clk(clk), .send(send), .ready_mode(ready_mode), .tx_sel(cfg_sh[5:4]),
    .src_ready(src_ready), .rx_bus(rx_bus), .first_req_bus(first_req_bus),
    .second_req_bus(second_req_bus), .src_valid(src_valid), .tx_feed_ready(tx_feed_ready));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk_val(input string what, input logic [9:0] e, input logic [9:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic close_out();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic guard(input int cnt, input int lim);
    if (cnt >= lim) begin
      error_cnt++;
      $display("mismatch wait_bound expected done seen timeout");
      close_out();
    end
  endtask

  function automatic psw_sym_type pick(input logic [1:0] s);
    case (s)
      SEL_RECEIVER: return rx_bus;
      SEL_FIRST_REQ: return first_req_bus;
      SEL_SECOND_REQ: return second_req_bus;
      default: return HALTW;
    endcase
  endfunction

  // One access; an idle cycle precedes it so cb_req never toggles twice in one step
  task automatic cb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                    input logic ref_e, input logic [7:0] rd_e);
    @(posedge clk);
    #1;
    cb_req = 1'b1;
    cb_cmd = '{wr, a, d};
    ackq.push_back({ref_e, rd_e});
    @(posedge clk);
    #1;
    cb_req = 1'b0;
    if (wr && !ref_e && a == CFG_ADDR) cfg_sh = d;
    if (wr && a == MODE_ADDR) mode_sh = d;
  endtask

  task automatic tload(input logic [7:0] v);
    @(posedge clk);
    #1;
    scrub_timer_loader = 1'b1;
    scrub_route_value = v;
    @(posedge clk);
    #1;
    scrub_timer_loader = 1'b0;
    scrub_route_value = ~v;
    cfg_sh = v;
  endtask

  task automatic drain();
    send = 1'b0;
    ready_mode = 2'h1;
    repeat (3) @(posedge clk);
    #1;
    n = 0;
    while (tx_feed_valid !== 1'b0 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    guard(n, 50);
  endtask

  always @(posedge clk) begin
    #1;
    tx_line_bit = 1'($urandom);
    if (rand_state) tx_state = 3'($urandom);
  end

  // ****************************************************************
  // Output watcher: results of cycle n are judged against causes of n-1
  // ****************************************************************
  always @(posedge clk) begin
    if (srst) begin
      armed = 1'b0;
      req_d = 1'b0;
      prev_nrzi = 1'b0;
      pol_age = 0;
    end else begin
      if (armed) begin
        chk_val("cb_ack", 10'(req_d), 10'(cb_ack));
        if (req_d) chk_val("cb_answer", 10'(ackq.pop_front()), {1'b0, cb_refused, cb_rdata});
        chk_val("first_ind_oe_n", 10'(e_oe_n[0]), 10'(first_ind_oe_n));
        chk_val("second_ind_oe_n", 10'(e_oe_n[1]), 10'(second_ind_oe_n));
        if (!e_oe_n[0]) chk_val("first_ind", e_first, first_ind);
        if (!e_oe_n[1]) chk_val("second_ind", e_second, second_ind);
        if (pol_age > 6) chk_val("pmd_on", 10'(e_on), 10'(pmd_transmitter_on_pin));
        if (pair_ok) chk_val("pmd_pair", 10'(e_pair), 10'(pmd_data_request_pair));
      end
      if (tx_feed_valid === 1'b1 && tx_feed_ready) begin
        if (halt_mode) begin
          chk_val("tx_feed_halt", (halt_cnt < 4) ? HALTW : IDLEW, tx_feed);
          halt_cnt++;
        end else begin
          chk_val("tx_feed", txq.pop_front(), tx_feed);
        end
      end
      if (cfg_sh[5:4] != SEL_INVALID && src_valid[cfg_sh[5:4]] && src_ready)
        txq.push_back(pick(cfg_sh[5:4]));
      // The polarity pin passes a synchroniser, so it is trusted only once settled
      pol_age = (enable_polarity_pin == pol_last) ? pol_age + 1 : 0;
      pol_last = enable_polarity_pin;
      e_first = pick(cfg_sh[1:0]);
      e_second = pick(cfg_sh[3:2]);
      e_oe_n = ~cfg_sh[7:6];
      e_on = ~((mode_sh[MODE_ALLOW_BIT] && tx_state != TM_OFF) ^ enable_polarity_pin);
      pair_ok = (tx_state == TM_OFF) || mode_sh[MODE_TX_NRZ_BIT] || prev_nrzi;
      prev_nrzi = (tx_state != TM_OFF) && !mode_sh[MODE_TX_NRZ_BIT];
      if (tx_state == TM_OFF) e_pair = mode_sh[MODE_QUIET_BIT] ? 2'b10 : 2'b01;
      else if (mode_sh[MODE_TX_NRZ_BIT]) e_pair = {tx_line_bit, ~tx_line_bit};
      else e_pair = {2{pmd_data_request_pair[1] ^ tx_line_bit}} ^ 2'b01;
      req_d = cb_req;
      armed = 1'b1;
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    guard(1, 1);
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    void'($urandom(66954));
    srst = 1'b1;
    cb_req = 1'b0;
    cb_cmd = '0;
    scrub_timer_loader = 1'b0;
    scrub_route_value = 8'h00;
    scrub_active = 1'b0;
    tx_state = TM_ACTIVE;
    rx_line_pin = 1'b0;
    enable_polarity_pin = 1'b1;
    pol_last = 1'b1;
    tx_line_bit = 1'b0;
    send = 1'b0;
    rand_state = 1'b0;
    ready_mode = 2'h1;
    halt_mode = 1'b1;
    mode_sh = MODE_RESET;
    cfg_sh = CFG_RESET;
    halt_cnt = 0;
    error_cnt = 0;
    num_checks = 0;
    repeat (3) @(posedge clk);
    #1;
    srst = 1'b0;
    // Reset route selects the invalid bus, so the halt burst starts at once
    cb(1'b0, MODE_ADDR, 8'h00, 1'b0, MODE_RESET);
    cb(1'b0, CFG_ADDR, 8'h00, 1'b0, CFG_RESET);
    cb(1'b0, 8'h5a, 8'h00, 1'b0, 8'h00);
    repeat (8) @(posedge clk);
    #1;
    chk_val("halt_seen", 10'h1, 10'(halt_cnt > 5));
    cb(1'b1, CFG_ADDR, 8'hd0, 1'b0, 8'h00);
    drain();
    halt_mode = 1'b0;
    send = 1'b1;
    rand_state = 1'b1;
    ready_mode = 2'h2;
    for (int i = 0; i < 16; i++) begin
      cb(1'b1, CFG_ADDR, {(i < 12) ? 2'b11 : 2'(i), (2'(i) == 2'h0) ? 2'h1 : 2'(i), 4'(i)},
         1'b0, 8'h00);
      cb(1'b0, CFG_ADDR, 8'h00, 1'b0, cfg_sh);
      repeat (4) @(posedge clk);
    end
    drain();
    send = 1'b1;
    ready_mode = 2'h0;
    n = 0;
    while (src_ready !== 1'b0 && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    guard(n, 60);
    chk_val("fifo_fill", 10'(FIFO_DEPTH), 10'(txq.size()));
    repeat (4) @(posedge clk);
    #1;
    chk_val("src_ready_full", 10'h0, 10'(src_ready));
    drain();
    for (int k = 0; k < 8; k++) begin
      cb(1'b1, MODE_ADDR, {1'b0, 3'(k), 4'(k + 3)}, 1'b0, 8'h00);
      cb(1'b0, MODE_ADDR, 8'h00, 1'b0, mode_sh);
      enable_polarity_pin = k[1];
      repeat (14) @(posedge clk);
    end
    scrub_active = 1'b1;
    cb(1'b1, CFG_ADDR, 8'hc0, 1'b1, 8'h00);
    scrub_active = 1'b0;
    cb(1'b0, CFG_ADDR, 8'h00, 1'b0, cfg_sh);
    fork
      cb(1'b1, CFG_ADDR, 8'hc0, 1'b1, 8'h00);
      tload(8'h9d);
    join
    cb(1'b0, CFG_ADDR, 8'h00, 1'b0, cfg_sh);
    tload(8'h6e);
    cb(1'b0, CFG_ADDR, 8'h00, 1'b0, cfg_sh);
    cb(1'b1, MODE_ADDR, 8'h80, 1'b0, 8'h00);
    for (int b = 0; b < 2; b++) begin
      rx_line_pin = b[0];
      repeat (8) @(posedge clk);
      #1;
      chk_val("rx_nrz", 10'(b[0]), 10'(rx_line_bit));
    end
    cb(1'b1, MODE_ADDR, 8'h00, 1'b0, 8'h00);
    repeat (8) @(posedge clk);
    #1;
    rx_line_pin = 1'b0;
    ones = 0;
    repeat (10) begin
      @(posedge clk);
      #1;
      ones += int'(rx_line_bit);
    end
    chk_val("rx_nrzi_ones", 10'h1, 10'(ones));
    rand_state = 1'b0;
    tx_state = TM_ACTIVE;
    halt_mode = 1'b1;
    halt_cnt = 0;
    cb(1'b1, CFG_ADDR, 8'hc0, 1'b0, 8'h00);
    repeat (12) @(posedge clk);
    #1;
    chk_val("halt_again", 10'h1, 10'(halt_cnt > 5));
    close_out();
  end
endmodule
